// ---- core/pfa_full_adder.sv ----
// single-bit pulse full adder with carry detect and sum suppression
// Notes on behaviour
// - each input passes its own pulse former giving an undelayed and a delayed copy.
// - exactly one input set gives sum and no carry.
// - exactly two inputs set, any two, give carry and no sum.
// - all three inputs set give both sum and carry.
// - carry rises when any pair of undelayed copies coincide.
// - a detected carry inhibits the OR of delayed copies onto the sum.
// - sum paths use the delayed copies so carry and suppression settle first.
// - coincidence of all three delayed copies drives the sum past the suppression.
// - no input set gives neither sum nor carry.
`timescale 1ns/1ps
module pfa_full_adder (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire pfa_pkg::pfa_in_t  in_pulse,
    output pfa_pkg::pfa_out_t      out_pulse
);
    //------------------------------------------------------------
    // input pulse formers
    //------------------------------------------------------------
    logic [2:0] in_vec;
    logic [2:0] now_v;
    logic [2:0] late_v;

    assign in_vec = {in_pulse.addend, in_pulse.augend, in_pulse.carry_in};

    // one former per input; operands come from same-clock logic, no sync
    for (genvar i = 0; i < 3; i++) begin : g_former
        pfa_pulse_former #(
            .DELAY (pfa_pkg::PFA_DELAY_CYCLES)
        ) u_former (
            .clock    (clock),
            .srst     (srst),
            .pulse_in (in_vec[i]),
            .now_out  (now_v[i]),
            .late_out (late_v[i])
        );
    end

    //------------------------------------------------------------
    // carry detection and sum gating
    //------------------------------------------------------------
    logic carry_hold_q;
    logic carry_hold_d;
    logic any_pair;
    logic sum_d;
    logic carry_d;
    logic sum_q;
    logic carry_q;
    logic pair_ab;
    logic pair_ac;
    logic pair_bc;
    logic triple_hit;
    logic or_any;
    logic or_gated;

    // paired coincidence gates on the undelayed copies; one pair is enough
    assign pair_ab  = now_v[2] & now_v[1];
    assign pair_ac  = now_v[2] & now_v[0];
    assign pair_bc  = now_v[1] & now_v[0];
    assign any_pair = pair_ab | pair_ac | pair_bc;

    // carry detect is held one step so it lines up with the delayed copies;
    // this is what lets suppression settle before any sum can pass
    always_comb begin
        carry_hold_d = any_pair;
        triple_hit   = &late_v;
        or_any       = |late_v;
        or_gated     = or_any & ~carry_hold_q;
        carry_d      = carry_hold_q;
        sum_d        = or_gated | triple_hit;
    end

    // registers only; outputs come straight from flip-flops
    always_ff @(posedge clock) begin
        if (srst) begin
            carry_hold_q <= pfa_pkg::PFA_RST_VAL;
            sum_q        <= pfa_pkg::PFA_RST_VAL;
            carry_q      <= pfa_pkg::PFA_RST_VAL;
        end else begin
            carry_hold_q <= carry_hold_d;
            sum_q        <= sum_d;
            carry_q      <= carry_d;
        end
    end

    assign out_pulse.sum   = sum_q;
    assign out_pulse.carry = carry_q;

    //------------------------------------------------------------
    // timing through the block
    //------------------------------------------------------------
    // edge 0: operands captured as the undelayed copies
    // edge 1: pairs latched as carry detect; copies move to the delayed taps
    // edge 2: sum and carry registered; they stand until the next edge
    // a checker sampling at edge 3 therefore sees the operands of edge 0
    // the carry leaves with the same skew as the sum, so a chain of places
    // pays three edges per place; whoever chains stages must wait for it

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    logic [1:0] cnt_in;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic       settled;

    assign cnt_in = 2'(in_vec[0]) + 2'(in_vec[1]) + 2'(in_vec[2]);

    // edges since reset; the pipe shows reset zeros until this saturates
    always_comb begin
        settle_d = settle_q;
        if (!(&settle_q)) begin
            settle_d = settle_q + 2'h1;
        end
    end

    // helper register only
    always_ff @(posedge clock) begin
        if (srst) begin
            settle_q <= 2'h0;
        end else begin
            settle_q <= settle_d;
        end
    end

    assign settled = &settle_q;

    a_one_sum: assert property (@(posedge clock) disable iff (srst)
        (cnt_in == 2'h1) |-> ##3 (out_pulse.sum && !out_pulse.carry))
        else $error("single input did not give sum only");
    a_two_carry: assert property (@(posedge clock) disable iff (srst)
        (cnt_in == 2'h2) |-> ##3 (!out_pulse.sum && out_pulse.carry))
        else $error("two inputs did not give carry only");
    a_three_both: assert property (@(posedge clock) disable iff (srst)
        (cnt_in == 2'h3) |-> ##3 (out_pulse.sum && out_pulse.carry))
        else $error("three inputs did not give sum and carry");
    a_none_quiet: assert property (@(posedge clock) disable iff (srst)
        (cnt_in == 2'h0) |-> ##3 (!out_pulse.sum && !out_pulse.carry))
        else $error("idle inputs gave an output");
    a_pair_carry: assert property (@(posedge clock) disable iff (srst)
        any_pair |-> ##2 out_pulse.carry)
        else $error("pair coincidence lost carry");
    a_sum_suppress: assert property (@(posedge clock) disable iff (srst)
        (carry_hold_q && !(&late_v)) |=> !out_pulse.sum)
        else $error("sum not suppressed by carry");
    a_triple_sum: assert property (@(posedge clock) disable iff (srst)
        (&late_v) |=> out_pulse.sum)
        else $error("triple coincidence gave no sum");
    a_late_align: assert property (@(posedge clock) disable iff (srst)
        $rose(any_pair) |=> (carry_hold_q && (|late_v)))
        else $error("carry detect not settled with delayed copies");
    a_former_copy: assert property (@(posedge clock) disable iff (srst)
        in_vec[2] |=> now_v[2] ##1 late_v[2])
        else $error("pulse former copies wrong");

    // augend and incoming carry formers behave the same
    a_former_augend: assert property (@(posedge clock) disable iff (srst)
        in_vec[1] |=> now_v[1] ##1 late_v[1])
        else $error("augend former copies wrong");

    a_former_cin: assert property (@(posedge clock) disable iff (srst)
        in_vec[0] |=> now_v[0] ##1 late_v[0])
        else $error("carry in former copies wrong");

    // an idle carry in must not leave a ghost pulse in either copy
    a_former_idle: assert property (@(posedge clock) disable iff (srst)
        !in_vec[0] |=> !now_v[0] ##1 !late_v[0])
        else $error("idle former produced a pulse");

    // whole-table checks once the pipe holds real operands
    a_sum_parity: assert property (@(posedge clock) disable iff (srst)
        settled |-> (out_pulse.sum == (^$past(in_vec, 3))))
        else $error("sum differs from operand parity");

    a_carry_major: assert property (@(posedge clock) disable iff (srst)
        settled |-> (out_pulse.carry == ($past(cnt_in, 3) >= 2'h2)))
        else $error("carry differs from operand majority");

    // each pair gate alone must raise the carry
    a_pair_ab: assert property (@(posedge clock) disable iff (srst)
        pair_ab |-> ##2 out_pulse.carry)
        else $error("addend augend pair lost carry");

    a_pair_ac: assert property (@(posedge clock) disable iff (srst)
        pair_ac |-> ##2 out_pulse.carry)
        else $error("addend carry pair lost carry");

    a_pair_bc: assert property (@(posedge clock) disable iff (srst)
        pair_bc |-> ##2 out_pulse.carry)
        else $error("augend carry pair lost carry");

    // no pair means no carry
    a_no_pair: assert property (@(posedge clock) disable iff (srst)
        !any_pair |-> ##2 !out_pulse.carry)
        else $error("carry without any pair");

    // an unsuppressed or path must reach the sum
    a_or_pass: assert property (@(posedge clock) disable iff (srst)
        (or_any && !carry_hold_q) |=> out_pulse.sum)
        else $error("or path blocked without carry");

    // sum only ever comes from the delayed taps
    a_sum_source: assert property (@(posedge clock) disable iff (srst)
        out_pulse.sum |-> $past(or_any))
        else $error("sum without delayed copy");

    a_sum_wait: assert property (@(posedge clock) disable iff (srst)
        (late_v == 3'h0) |=> !out_pulse.sum)
        else $error("sum ahead of delayed copies");

    // carry leaves from the held detect, not straight from the gates
    a_carry_source: assert property (@(posedge clock) disable iff (srst)
        out_pulse.carry |-> $past(carry_hold_q))
        else $error("carry without held detect");

    // all three set raise the carry as well as the sum
    a_triple_carry: assert property (@(posedge clock) disable iff (srst)
        (&now_v) |-> ##2 out_pulse.carry)
        else $error("triple input lost carry");

    // reset leaves both outputs quiet
    a_reset_quiet: assert property (@(posedge clock)
        srst |=> (!out_pulse.sum && !out_pulse.carry))
        else $error("outputs active after reset");
endmodule

// ---- core/pfa_pkg.sv ----
// package for the pulse full adder: delays and carrier types
package pfa_pkg;
    // cycles between the undelayed and delayed copy of an input pulse
    localparam int unsigned PFA_DELAY_CYCLES = 1;
    // reset value of every pulse stage
    localparam logic        PFA_RST_VAL      = 1'h0;

    // the three operand pulses presented in one timing interval
    typedef struct packed {
        logic addend;
        logic augend;
        logic carry_in;
    } pfa_in_t;

    // result pulses towards the operand logic and the next place
    typedef struct packed {
        logic sum;
        logic carry;
    } pfa_out_t;
endpackage

// ---- core/pfa_pulse_former.sv ----
// input pulse former: registered undelayed copy plus delayed copy
`timescale 1ns/1ps
module pfa_pulse_former #(
    parameter int unsigned DELAY = pfa_pkg::PFA_DELAY_CYCLES
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic pulse_in,
    output logic      now_out,
    output logic      late_out
);
    logic [DELAY-1:0] line_q;
    logic [DELAY-1:0] line_d;
    logic             now_q;
    logic             now_d;

    // next values: capture the pulse, then shift it down the delay line
    // the undelayed copy enters at the top and leaves at bit 0
    always_comb begin
        now_d           = pulse_in;
        line_d          = line_q;
        line_d[DELAY-1] = now_q;
        for (int k = 0; k < DELAY - 1; k++) begin
            line_d[k] = line_q[k+1];
        end
    end

    // registers only
    always_ff @(posedge clock) begin
        if (srst) begin
            now_q  <= pfa_pkg::PFA_RST_VAL;
            line_q <= {DELAY{pfa_pkg::PFA_RST_VAL}};
        end else begin
            now_q  <= now_d;
            line_q <= line_d;
        end
    end

    assign now_out  = now_q;
    assign late_out = line_q[0];
endmodule

// ---- tb/pfa_full_adder_tb.sv ----
// self-checking bench for the pulse full adder
`timescale 1ns/1ps
module pfa_full_adder_tb;
    logic              clock;
    logic              srst;
    logic [2:0]        operand;
    pfa_pkg::pfa_in_t  in_pulse;
    pfa_pkg::pfa_out_t out_pulse;
    int                fail_count;
    int                samples_checked;

    pfa_operand_src i_pfa_operand_src (.operand(operand), .in_pulse(in_pulse));
    pfa_full_adder  i_pfa_full_adder (.clock(clock), .srst(srst), .in_pulse(in_pulse),
                                      .out_pulse(out_pulse));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // reference sum and carry, worked out bit by bit
    function automatic pfa_pkg::pfa_out_t adder_ref(input logic [2:0] v);
        pfa_pkg::pfa_out_t r;
        r.sum   = ^v;
        r.carry = (v[2] & v[1]) | (v[2] & v[0]) | (v[1] & v[0]);
        return r;
    endfunction

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // all eight codes back to back; descending order flips every neighbour pair
    task automatic test_truth_table(input logic rev);
        logic [2:0] code;
        for (int j = 0; j < 11; j++) begin
            code = rev ? 3'(7 - (j % 8)) : 3'(j % 8);
            @(posedge clock);
            operand <= (j < 8) ? code : 3'h0;
            #1;
            // output lags the driven code by three edges
            code = rev ? 3'(10 - j) : 3'(j - 3);
            if (j >= 3) check("out_pulse", 8'(out_pulse), 8'(adder_ref(code)));
        end
        $display("test truth_table rev=%0d done", rev);
    endtask

    // serial addition, lsb first, each carry fed back as the next carry in
    task automatic test_ripple(input logic [3:0] a, input logic [3:0] b);
        logic [4:0] total;
        logic       cy;
        cy    = 1'b0;
        total = 5'h00;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            operand <= {a[k], b[k], cy};
            @(posedge clock);
            operand <= 3'h0;
            repeat (2) @(posedge clock);
            #1;
            total[k] = out_pulse.sum;
            cy       = out_pulse.carry;
        end
        total[4] = cy;
        check("ripple_total", 8'(total), 8'(a) + 8'(b));
        $display("test ripple done");
    endtask

    // ----------------------------------------
    // clock, sequence and watchdog
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        fail_count      = 0;
        samples_checked = 0;
        srst            = 1'b1;
        operand         = 3'h0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        test_truth_table(1'b0);
        test_truth_table(1'b1);
        test_ripple(4'hb, 4'h7);
        test_ripple(4'hf, 4'hf);
        finish_test();
    end

    // run needs about 60 cycles; allow ample margin
    initial begin
        #5000;
        fail_count++;
        finish_test();
    end
endmodule

// ---- tb/pfa_operand_src.sv ----
// operand source model that feeds the three pulses of the adder
`timescale 1ns/1ps
module pfa_operand_src (
    input  wire logic [2:0]   operand,
    output pfa_pkg::pfa_in_t  in_pulse
);
    // all three pulses leave together, so they share one interval
    assign in_pulse = pfa_pkg::pfa_in_t'(operand);
endmodule
